// File: hdl/ocsc_top.sv
// Top level: register bus, line registers, summaries and scanner
`timescale 1ns/1ps
// Notes on behaviour
// - Eight independent full-duplex serial lines run side by side.
// - Sixteen bit rates, 50 to 19200 baud, from an internal generator.
// - Stop bits, parity and length are set per line.
// - Scanner checks all lines, receiver conditions before transmitter ones.
// - Both modem enables plus receive interrupt enable let modem changes interrupt.
// - Receive path is an assembly stage then a two-entry buffer.
// - Transmit path has a holding register ahead of the serializer.
// - Status register is read-only; writes do nothing.
// - Mode one holds stops, parity, length and modem interrupt enable.
// - Mode two holds receive and transmit rate selects.
// - Interrupt summary shows pending, line number and direction.
// - Modem change summary keeps one sticky flag per line.
// - Data lines driven only for chip select, strobe low, write high.
// - Data lines release within 50 ns of the read ending.
// - Six address bits pick the register while strobe and select are low.
// - Receive buffer and holding register share an address; direction chooses.
// - Interrupt output plus three line-number outputs.
// - Direction output tells transmit from receive interrupt.
// - Ready output signals readiness for a bus transfer.
// - All rate and internal timing comes from the one clock.
// - Upper three address bits pick the line, lower three the register.
// - Transmit line idles high and is held low during break.
// - Reset forces transmit lines low and clears receive and error status.
module ocsc_top #(
    parameter int CLK_HZ = ocsc_pkg::CLK_HZ
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Parallel register bus
    input wire logic cs_n,
    input wire logic data_strobe_first_n,
    input wire logic data_strobe_second_n,
    input wire logic wr_n,
    input wire logic [5:0] addr,
    input wire logic [7:0] parallel_data_lines_in,
    output logic [7:0] parallel_data_lines_out,
    output logic parallel_data_lines_oe,
    output logic rdy_n_out,
    output logic rdy_oe,
    // Interrupt request
    output logic irq_n_out,
    output logic irq_oe,
    output logic [2:0] interrupt_channel_num,
    output logic interrupt_direction_flag,
    // Serial lines and modem inputs
    input wire logic [ocsc_pkg::NCH-1:0] rxd,
    output logic [ocsc_pkg::NCH-1:0] txd,
    input wire logic [ocsc_pkg::NCH-1:0] dsr_n,
    input wire logic [ocsc_pkg::NCH-1:0] dcd_n
);
    import ocsc_pkg::*;

    typedef struct packed {
        logic [NCH-1:0][7:0] m1;
        logic [NCH-1:0][7:0] m2;
        logic [NCH-1:0][7:0] cmd;
        logic [NCH-1:0] mptr;
        logic [NCH-1:0] dsc;
        logic [NCH-1:0] dsr_p;
        logic [NCH-1:0] dcd_p;
        logic mvld;
        logic stb_p;
        logic wpend;
        logic rpend;
        logic [5:0] ba;
        logic [7:0] bd;
        logic [7:0] dl;
        logic dl_oe;
        logic rdy_oe;
        logic irq_oe;
        logic [2:0] ln;
        logic dir;
        logic od_lo;
    } ocsc_top_t;

    ocsc_top_t t_q, t_d;

    logic stb;
    logic acc;
    logic rd_act;
    logic fin;
    logic wr_go;
    logic rd_go;
    logic [2:0] rch;
    logic [7:0] rv;
    logic [NCH-1:0] thr_load;
    logic [NCH-1:0] rx_pop;
    logic [NCH-1:0] err_clr;
    logic [NCH-1:0] rxq;
    logic [NCH-1:0] txq;
    logic [NCH-1:0] chg;
    logic [NCH-1:0] dclr;
    logic [NCH-1:0][7:0] rxd_v;
    logic [NCH-1:0][5:0] stat_v;

    // True when a latched address names register r of line c
    function automatic logic ocsc_hit(input logic [5:0] a, input int c, input logic [2:0] r);
        return a[5:3] == c[2:0] && a[2:0] == r;
    endfunction : ocsc_hit

    // Lowest line with a request wins
    function automatic logic [2:0] ocsc_first(input logic [NCH-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int k = NCH - 1; k >= 0; k--) begin
            if (v[k]) begin
                n = 3'(k);
            end
        end
        return n;
    endfunction : ocsc_first

    // Only a cycle with both strobes low counts as strobed
    assign stb = !data_strobe_first_n && !data_strobe_second_n;
    assign acc = stb && !cs_n;
    assign rd_act = acc && wr_n;
    assign fin = t_q.stb_p && !acc;
    assign wr_go = fin && t_q.wpend;
    assign rd_go = fin && t_q.rpend;
    assign rch = addr[5:3];

    always_comb begin
        t_d = t_q;
        thr_load = '0;
        rx_pop = '0;
        err_clr = '0;
        dclr = '0;

        // Read data, taken from the live address while the cycle runs
        case (addr[2:0])
            R_DATA: rv = rxd_v[rch];
            R_STAT: rv = {!t_q.dsr_p[rch], t_q.dcd_p[rch], stat_v[rch]};
            R_MODE: rv = t_q.mptr[rch] ? t_q.m2[rch] : t_q.m1[rch];
            R_CMD: rv = t_q.cmd[rch];
            R_ISUM: rv = {t_q.irq_oe, 3'h0, t_q.ln, t_q.dir};
            R_DSUM: rv = t_q.dsc;
            default: rv = 8'h00;
        endcase
        t_d.dl = rv;
        t_d.dl_oe = rd_act;
        t_d.rdy_oe = !cs_n;
        t_d.od_lo = 1'b0;

        // Bus cycle tracking; the write lands when the strobe ends
        t_d.stb_p = acc;
        if (acc) begin
            t_d.ba = addr;
            if (wr_n) begin
                t_d.rpend = 1'b1;
            end else begin
                t_d.wpend = 1'b1;
                t_d.bd = parallel_data_lines_in;
            end
        end
        if (fin) begin
            t_d.wpend = 1'b0;
            t_d.rpend = 1'b0;
        end

        for (int i = 0; i < NCH; i++) begin
            thr_load[i] = wr_go && ocsc_hit(t_q.ba, i, R_DATA);
            rx_pop[i] = rd_go && ocsc_hit(t_q.ba, i, R_DATA);
            err_clr[i] = wr_go && ocsc_hit(t_q.ba, i, R_CMD) && t_q.bd[CMD_ERRCLR];
            if (wr_go && ocsc_hit(t_q.ba, i, R_MODE)) begin
                if (t_q.mptr[i]) begin
                    t_d.m2[i] = t_q.bd;
                end else begin
                    t_d.m1[i] = t_q.bd;
                end
            end
            // Mode one and two share an address; each access steps to the other
            if ((wr_go || rd_go) && ocsc_hit(t_q.ba, i, R_MODE)) begin
                t_d.mptr[i] = !t_q.mptr[i];
            end
            if (wr_go && ocsc_hit(t_q.ba, i, R_CMD)) begin
                t_d.cmd[i] = t_q.bd;
            end
        end

        // Modem change flags: writing ones clears, a fresh change wins
        if (wr_go && t_q.ba[2:0] == R_DSUM) begin
            dclr = t_q.bd;
        end
        t_d.dsr_p = dsr_n;
        t_d.dcd_p = dcd_n;
        t_d.mvld = 1'b1;
        chg = t_q.mvld ? ((dsr_n ^ t_q.dsr_p) | (dcd_n ^ t_q.dcd_p)) : '0;
        t_d.dsc = (t_q.dsc & ~dclr) | chg;

        // Scanner
        for (int i = 0; i < NCH; i++) begin
            rxq[i] = t_q.cmd[i][CMD_RXIE] && (stat_v[i][ST_RXRDY]
                || (t_q.dsc[i] && t_q.m1[i][M1_MODEM_CHANGE_IRQ_ENABLE] && t_q.cmd[i][CMD_MODEM_CHANGE_IRQ_ENABLE]));
            txq[i] = t_q.cmd[i][CMD_TXIE] && t_q.cmd[i][CMD_TXEN] && stat_v[i][ST_THRE];
        end
        t_d.irq_oe = |rxq || |txq;
        if (|rxq) begin
            t_d.ln = ocsc_first(rxq);
            t_d.dir = 1'b0;
        end else if (|txq) begin
            t_d.ln = ocsc_first(txq);
            t_d.dir = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            t_q <= '0;
            t_q.m1 <= {NCH{M1_RST}};
            t_q.m2 <= {NCH{M2_RST}};
            t_q.cmd <= {NCH{CMD_RST}};
        end else if (ce) begin
            t_q <= t_d;
        end
    end

    // Each line runs on its own state, sharing the clock, reset, enable and write data
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        ocsc_chan #(
            .CLK_HZ(CLK_HZ)
        ) u_ch (
            .core_clk(core_clk),
            .rstn(rstn),
            .ce(ce),
            .mode1(t_q.m1[i]),
            .mode2(t_q.m2[i]),
            .cmd(t_q.cmd[i]),
            .thr_load(thr_load[i]),
            .thr_data(t_q.bd),
            .rx_pop(rx_pop[i]),
            .err_clr(err_clr[i]),
            .rx_data(rxd_v[i]),
            .stat(stat_v[i]),
            .rxd(rxd[i]),
            .txd(txd[i])
        );
    end

    assign parallel_data_lines_out = t_q.dl;
    assign parallel_data_lines_oe = t_q.dl_oe;
    assign rdy_n_out = t_q.od_lo;
    assign rdy_oe = t_q.rdy_oe;
    assign irq_n_out = t_q.od_lo;
    assign irq_oe = t_q.irq_oe;
    assign interrupt_channel_num = t_q.ln;
    assign interrupt_direction_flag = t_q.dir;

    localparam int REL_LIM = REL_CYC;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_rd_cycle;
        ce && !cs_n && stb && wr_n;
    endsequence

    sequence s_wr_end;
        t_q.stb_p && !acc && t_q.wpend;
    endsequence

    property p_drive;
        ce ##1 parallel_data_lines_oe |-> $past(rd_act);
    endproperty
    a_drive: assert property (p_drive) else $error("data lines driven outside read");

    property p_drive_on;
        s_rd_cycle |=> parallel_data_lines_oe && parallel_data_lines_out == $past(rv);
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("read data not driven");

    property p_release;
        ce && !rd_act |-> ##[1:REL_LIM] !parallel_data_lines_oe;
    endproperty
    a_release: assert property (p_release) else $error("data lines not released");

    property p_ready;
        ce |=> rdy_oe == !$past(cs_n);
    endproperty
    a_ready: assert property (p_ready) else $error("ready wrong");

    property p_rx_first;
        ce && |rxq |=> irq_oe && !interrupt_direction_flag
            && interrupt_channel_num == ocsc_first($past(rxq));
    endproperty
    a_rx_first: assert property (p_rx_first) else $error("receiver not first");

    property p_tx_irq;
        ce && !(|rxq) && |txq |=> irq_oe && interrupt_direction_flag;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit request missed");

    property p_no_irq;
        ce && !(|rxq) && !(|txq) |=> !irq_oe;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("spurious interrupt");

    property p_dsc_sticky;
        ce && |chg |=> (t_q.dsc & $past(chg)) == $past(chg);
    endproperty
    a_dsc_sticky: assert property (p_dsc_sticky) else $error("change flag lost");

    property p_one_write;
        |thr_load |-> s_wr_end;
    endproperty
    a_one_write: assert property (p_one_write) else $error("write off strobe end");

    property p_stat_ro;
        ce && wr_go && t_q.ba[2:0] == R_STAT |=> $stable(t_q.m1) && $stable(t_q.cmd);
    endproperty
    a_stat_ro: assert property (p_stat_ro) else $error("status write had effect");

    property p_modem_irq;
        ce && t_q.dsc[0] && t_q.m1[0][M1_MODEM_CHANGE_IRQ_ENABLE] && t_q.cmd[0][CMD_MODEM_CHANGE_IRQ_ENABLE]
            && t_q.cmd[0][CMD_RXIE] |=> irq_oe && !interrupt_direction_flag
            && interrupt_channel_num == 3'h0;
    endproperty
    a_modem_irq: assert property (p_modem_irq) else $error("modem change ignored");
endmodule : ocsc_top

// File: hdl/ocsc_pkg.sv
// Constants, types and helpers shared by the octal serial controller
package ocsc_pkg;
    localparam int NCH = 8;
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_NS = 8;
    localparam int REL_NS = 50;
    localparam int REL_CYC = (REL_NS / CLK_NS < 1) ? 1 : REL_NS / CLK_NS;
    localparam int OVS = 16;
    localparam int DIV_W = 20;
    localparam int HALF_BIT = 8;
    // Register select, low three address bits
    localparam logic [2:0] R_DATA = 3'h0;
    localparam logic [2:0] R_STAT = 3'h1;
    localparam logic [2:0] R_MODE = 3'h2;
    localparam logic [2:0] R_CMD = 3'h3;
    localparam logic [2:0] R_ISUM = 3'h4;
    localparam logic [2:0] R_DSUM = 3'h5;
    // Mode 1 fields
    localparam int M1_LEN = 0;
    localparam int M1_PEN = 2;
    localparam int M1_ODD = 3;
    localparam int M1_STOP2 = 4;
    localparam int M1_MODEM_CHANGE_IRQ_ENABLE = 5;
    // Command fields
    localparam int CMD_TXEN = 0;
    localparam int CMD_TXIE = 1;
    localparam int CMD_RXEN = 2;
    localparam int CMD_RXIE = 3;
    localparam int CMD_BRK = 4;
    localparam int CMD_ERRCLR = 5;
    localparam int CMD_MODEM_CHANGE_IRQ_ENABLE = 6;
    // Status fields
    localparam int ST_THRE = 0;
    localparam int ST_RXRDY = 1;
    localparam int ST_TXIDLE = 2;
    localparam int ST_PERR = 3;
    localparam int ST_OVR = 4;
    localparam int ST_FERR = 5;
    localparam int ST_DCD = 6;
    localparam int ST_DSR = 7;
    localparam int ISUM_PEND = 7;
    localparam logic [7:0] M1_RST = 8'h03;
    localparam logic [7:0] M2_RST = 8'hEE;
    localparam logic [7:0] CMD_RST = 8'h00;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_START = 5'h02,
        S_DATA = 5'h04,
        S_PAR = 5'h08,
        S_STOP = 5'h10
    } ocsc_ser_t;

    // Clock cycles per sixteenth of a bit for each of the 16 rates
    function automatic logic [DIV_W-1:0] ocsc_div(input int hz, input logic [3:0] sel);
        longint b10;
        longint d;
        case (sel)
            4'h0: b10 = 500;
            4'h1: b10 = 750;
            4'h2: b10 = 1100;
            4'h3: b10 = 1345;
            4'h4: b10 = 1500;
            4'h5: b10 = 3000;
            4'h6: b10 = 6000;
            4'h7: b10 = 12000;
            4'h8: b10 = 18000;
            4'h9: b10 = 20000;
            4'hA: b10 = 24000;
            4'hB: b10 = 36000;
            4'hC: b10 = 48000;
            4'hD: b10 = 72000;
            4'hE: b10 = 96000;
            default: b10 = 192000;
        endcase
        d = (longint'(hz) * 10) / (b10 * OVS);
        if (d < 1) begin
            d = 1;
        end
        return DIV_W'(d);
    endfunction : ocsc_div

    // Mask of the live data bits for a character length code
    function automatic logic [7:0] ocsc_mask(input logic [1:0] len);
        return 8'hFF >> (2'h3 - len);
    endfunction : ocsc_mask
endpackage : ocsc_pkg

// File: hdl/ocsc_chan.sv
// One serial line: receiver with two-entry buffer and transmitter
`timescale 1ns/1ps
module ocsc_chan #(
    parameter int CLK_HZ = ocsc_pkg::CLK_HZ
) (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Line settings
    input wire logic [7:0] mode1,
    input wire logic [7:0] mode2,
    input wire logic [7:0] cmd,
    // Buffer access
    input wire logic thr_load,
    input wire logic [7:0] thr_data,
    input wire logic rx_pop,
    input wire logic err_clr,
    output logic [7:0] rx_data,
    output logic [5:0] stat,
    // Serial pins
    input wire logic rxd,
    output logic txd
);
    import ocsc_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] rdiv;
        logic [DIV_W-1:0] tdiv;
        ocsc_ser_t rs;
        logic [3:0] rph;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic [3:0] hi;
        logic perr;
        logic [1:0][9:0] fifo;
        logic [1:0] fcnt;
        logic frp;
        logic ovr;
        ocsc_ser_t ts;
        logic [4:0] tph;
        logic [2:0] tbit;
        logic [7:0] tsh;
        logic tpar;
        logic [7:0] thr;
        logic thr_full;
        logic txd;
    } ocsc_chs_t;

    ocsc_chs_t s_q, s_d;
    logic rtick, ttick, tline;
    logic [2:0] nlast;
    logic [7:0] msk, rword;

    always_comb begin
        s_d = s_q;
        nlast = 3'h4 + {1'b0, mode1[M1_LEN +: 2]};
        msk = ocsc_mask(mode1[M1_LEN +: 2]);
        rword = s_q.rsh >> (3'h7 - nlast);
        rtick = s_q.rdiv >= ocsc_div(CLK_HZ, mode2[3:0]) - 1'b1;
        ttick = s_q.tdiv >= ocsc_div(CLK_HZ, mode2[7:4]) - 1'b1;
        s_d.rdiv = rtick ? '0 : s_q.rdiv + 1'b1;
        s_d.tdiv = ttick ? '0 : s_q.tdiv + 1'b1;
        // Pop before push, so a read in the same cycle makes room
        if (rx_pop && s_q.fcnt != 2'h0) begin
            s_d.frp = !s_q.frp;
            s_d.fcnt = s_q.fcnt - 2'h1;
        end
        if (err_clr) begin
            s_d.ovr = 1'b0;
        end
        if (rtick) begin
            s_d.rph = s_q.rph + 4'h1;
            case (s_q.rs)
                S_IDLE: begin
                    s_d.rph = 4'h0;
                    s_d.hi = !rxd ? 4'h0 : (s_q.hi == 4'(HALF_BIT) ? s_q.hi : s_q.hi + 4'h1);
                    if (!rxd && s_q.hi == 4'(HALF_BIT) && cmd[CMD_RXEN]) begin
                        s_d.rs = S_START;
                    end
                end
                S_START: if (s_q.rph == 4'h7) begin
                    s_d.rph = 4'h0;
                    s_d.rbit = 3'h0;
                    s_d.perr = 1'b0;
                    s_d.rs = rxd ? S_IDLE : S_DATA;
                end
                S_DATA: if (s_q.rph == 4'hF) begin
                    s_d.rsh = {rxd, s_q.rsh[7:1]};
                    s_d.rbit = s_q.rbit + 3'h1;
                    if (s_q.rbit == nlast) begin
                        s_d.rs = mode1[M1_PEN] ? S_PAR : S_STOP;
                    end
                end
                S_PAR: if (s_q.rph == 4'hF) begin
                    s_d.perr = rxd ^ (^(rword & msk)) ^ mode1[M1_ODD];
                    s_d.rs = S_STOP;
                end
                S_STOP: if (s_q.rph == 4'hF) begin
                    s_d.rs = S_IDLE;
                    // Overrun wins over a clear in the same cycle
                    if (s_d.fcnt == 2'h2) begin
                        s_d.ovr = 1'b1;
                    end else begin
                        s_d.fifo[s_d.frp ^ s_d.fcnt[0]] = {!rxd, s_q.perr, rword};
                        s_d.fcnt = s_d.fcnt + 2'h1;
                    end
                end
                default: s_d.rs = S_IDLE;
            endcase
        end
        if (ttick) begin
            s_d.tph = s_q.tph + 5'h1;
            case (s_q.ts)
                S_IDLE: begin
                    s_d.tph = 5'h0;
                    if (s_q.thr_full && cmd[CMD_TXEN]) begin
                        s_d.tsh = s_q.thr;
                        s_d.tpar = (^(s_q.thr & msk)) ^ mode1[M1_ODD];
                        s_d.thr_full = 1'b0;
                        s_d.ts = S_START;
                    end
                end
                S_START: if (s_q.tph == 5'hF) begin
                    s_d.tph = 5'h0;
                    s_d.tbit = 3'h0;
                    s_d.ts = S_DATA;
                end
                S_DATA: if (s_q.tph == 5'hF) begin
                    s_d.tph = 5'h0;
                    s_d.tsh = s_q.tsh >> 1;
                    s_d.tbit = s_q.tbit + 3'h1;
                    if (s_q.tbit == nlast) begin
                        s_d.ts = mode1[M1_PEN] ? S_PAR : S_STOP;
                    end
                end
                S_PAR: if (s_q.tph == 5'hF) begin
                    s_d.tph = 5'h0;
                    s_d.ts = S_STOP;
                end
                S_STOP: if (s_q.tph == (mode1[M1_STOP2] ? 5'h1F : 5'hF)) begin
                    s_d.ts = S_IDLE;
                end
                default: s_d.ts = S_IDLE;
            endcase
        end
        // New character replaces one still waiting
        if (thr_load) begin
            s_d.thr = thr_data;
            s_d.thr_full = 1'b1;
        end
        case (s_q.ts)
            S_START: tline = 1'b0;
            S_DATA: tline = s_q.tsh[0];
            S_PAR: tline = s_q.tpar;
            default: tline = 1'b1;
        endcase
        s_d.txd = !cmd[CMD_BRK] && tline;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.rs <= S_IDLE;
            s_q.ts <= S_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign txd = s_q.txd;
    assign rx_data = s_q.fifo[s_q.frp][7:0];
    assign stat[ST_THRE] = !s_q.thr_full;
    assign stat[ST_RXRDY] = s_q.fcnt != 2'h0;
    assign stat[ST_TXIDLE] = s_q.ts == S_IDLE;
    assign stat[ST_PERR] = stat[ST_RXRDY] && s_q.fifo[s_q.frp][8];
    assign stat[ST_OVR] = s_q.ovr;
    assign stat[ST_FERR] = stat[ST_RXRDY] && s_q.fifo[s_q.frp][9];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_brk_low;
        ce && cmd[CMD_BRK] |=> !txd;
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break not low");

    property p_idle_high;
        ce && !cmd[CMD_BRK] && s_q.ts == S_IDLE && !ttick |=> txd;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line not high");

    property p_fifo_bound;
        s_q.fcnt <= 2'h2;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("buffer count");

    property p_thr_load;
        ce && thr_load |=> s_q.thr_full && s_q.thr == $past(thr_data);
    endproperty
    a_thr_load: assert property (p_thr_load) else $error("holding load lost");
endmodule : ocsc_chan

// File: verification/ocsc_bus_model.sv
// Bus master model for the parallel register port
`timescale 1ns/1ps
module ocsc_bus_model (
    // Clock
    input wire logic core_clk,
    // Bus
    output logic cs_n,
    output logic ds_n,
    output logic wr_n,
    output logic [5:0] addr,
    output logic [7:0] dout,
    input wire logic [7:0] din
);
    logic [7:0] rdat;
    initial begin
        {cs_n, ds_n, wr_n, addr, dout} = {3'h7, 14'h0};
    end
    // One access; bus held until after the strobe has been seen high
    task automatic cyc(input logic [5:0] a, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        {cs_n, wr_n, addr, dout} = {1'b0, ~w, a, d};
        ds_n = 1'b0; // one strobe feeds both pins
        repeat (2) @(posedge core_clk);
        #1;
        rdat = din;
        ds_n = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        cs_n = 1'b1;
        // Released data bus must not look like the last value
        dout = ~d;
    endtask : cyc
endmodule : ocsc_bus_model

// File: verification/testbench.sv
// Self-checking bench for the octal serial controller
`timescale 1ns/1ps
module testbench;
    import ocsc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [NCH-1:0] dsr_n = 8'hFF;
    logic cs_n, ds_n, wr_n, oe, rdy_oe, irq_oe, dir;
    logic [5:0] addr;
    logic [7:0] dout, din, dq, v;
    logic [2:0] chn;
    logic [NCH-1:0] txd;
    logic [7:0] m1 [4];
    logic [7:0] m2 [4];
    int err_total = 0;
    int n_compared = 0;
    always #4 core_clk = ~core_clk;
    ocsc_bus_model bm (.core_clk(core_clk), .cs_n(cs_n), .ds_n(ds_n), .wr_n(wr_n),
        .addr(addr), .dout(dout), .din(din));
    // Short divisors keep a character near 1600 clocks; serial lines looped back
    ocsc_top #(.CLK_HZ(1_600_000)) uut (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
        .cs_n(cs_n), .data_strobe_first_n(ds_n), .data_strobe_second_n(ds_n), .wr_n(wr_n),
        .addr(addr), .parallel_data_lines_in(dout), .parallel_data_lines_out(dq),
        .parallel_data_lines_oe(oe), .rdy_n_out(), .rdy_oe(rdy_oe), .irq_n_out(),
        .irq_oe(irq_oe), .interrupt_channel_num(chn), .interrupt_direction_flag(dir),
        .rxd(txd), .txd(txd), .dsr_n(dsr_n), .dcd_n(8'hFF));
    // Undriven data bus reads as the inverse of its last value
    assign din = oe ? dq : ~dq;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bm.cyc(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        bm.cyc(a, 1'b0, 8'h00);
        chk(bm.rdat, exp);
        // Ready follows chip select one clock late
        @(posedge core_clk);
        #1;
        chk({6'h0, oe, rdy_oe}, 8'h00);
    endtask : rd
    function automatic logic [7:0] isum(input logic [2:0] l, input logic d);
        return {1'b1, 3'h0, l, d};
    endfunction : isum
    task automatic irq_is(input logic [2:0] l, input logic d);
        chk({3'h0, irq_oe, dir, chn}, {3'h0, 1'b1, d, l});
    endtask : irq_is
    task automatic test_done();
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #200_000;
        err_total++;
        test_done();
    end
    initial begin
        void'($urandom(32'h0bf5));
        repeat (4) @(posedge core_clk);
        #1;
        chk(txd, 8'h00);
        rstn = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk(txd, 8'hFF);
        for (int l = 0; l < 4; l++) begin
            m1[l] = 8'($urandom()) & 8'h3F;
            m2[l] = 8'($urandom());
            wr({l[2:0], R_MODE}, m1[l]);
            wr({l[2:0], R_MODE}, m2[l]);
        end
        for (int l = 0; l < 4; l++) begin
            rd({l[2:0], R_MODE}, m1[l]);
            rd({l[2:0], R_MODE}, m2[l]);
        end
        rd(6'h29, 8'h45);
        wr(6'h29, 8'h00);
        rd(6'h29, 8'h45);
        wr(6'h3B, 8'h10);
        repeat (2) @(posedge core_clk);
        chk(txd, 8'h7F);
        wr(6'h3B, 8'h00);
        repeat (2) @(posedge core_clk);
        chk(txd, 8'hFF);
        wr(6'h33, 8'h03);
        wr(6'h13, 8'h03);
        repeat (3) @(posedge core_clk);
        irq_is(3'h2, 1'b1);
        rd(6'h3C, isum(3'h2, 1'b1));
        v = 8'($urandom());
        wr(6'h2B, 8'h0D);
        wr(6'h28, v);
        // Receiver on line 5 must take over from the waiting transmitter
        for (int i = 0; i < 5000 && !(irq_oe === 1'b1 && dir === 1'b0); i++) begin
            @(posedge core_clk);
            #1;
        end
        irq_is(3'h5, 1'b0);
        rd(6'h28, v);
        repeat (3) @(posedge core_clk);
        #1;
        irq_is(3'h2, 1'b1);
        dsr_n[3] = 1'b0;
        repeat (4) @(posedge core_clk);
        rd(6'h05, 8'h08);
        wr(6'h05, 8'h08);
        rd(6'h05, 8'h00);
        // Modem change on line 0 with both modem enables and receive interrupt on
        wr(6'h02, m1[0] | 8'h20);
        wr(6'h03, 8'h48);
        dsr_n[0] = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        irq_is(3'h0, 1'b0);
        rd(6'h05, 8'h01);
        test_done();
    end
endmodule : testbench
